/* File: bench/rail_model.sv */
// Behavioural rails: feedback follows each enable after a set lag.
// Assumes the bench sets the lag and which rails fail to come up.
`timescale 1ns/1ps
`default_nettype none
module rail_model (
    input wire logic clk_i,
    input wire seq_timer_pkg::rail_ctrl_s rail_i,
    input wire logic [7:0] lag_i,
    input wire logic [3:0] stuck_i,
    output logic [3:0] good_o
);
    logic [7:0] cnt_q [4]; // Ramp progress per rail
    initial
    begin
        good_o = '0;
        cnt_q = '{default: '0};
    end
    // Ramp up or bleed down; a stuck rail never reaches threshold
    always @(posedge clk_i)
        for (int c = 0; c < 4; c++)
            if (rail_i.enable[c] == good_o[c] || (rail_i.enable[c] && stuck_i[c]))
                cnt_q[c] <= '0;
            else if (cnt_q[c] == lag_i)
                good_o[c] <= rail_i.enable[c];
            else
                cnt_q[c] <= cnt_q[c] + 8'h01;
endmodule
`default_nettype wire

/* File: bench/seq_timers_properties.sv */
// Checker bound onto seq_timers; it sees the core's ports only.
// Assumes the pulse length parameter matches the core's.
`timescale 1ns/1ps
`default_nettype none
module seq_timers_properties
    import seq_timer_pkg::*;
#(
    parameter logic [seq_timer_pkg::CNT_W-1:0] DISCHARGE = seq_timer_pkg::DISCHARGE_CYC,
    parameter logic [seq_timer_pkg::CNT_W-1:0] FAULT_PULSE = seq_timer_pkg::FAULT_PULSE_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic input_undervoltage_sense_i,
    input wire logic fault_line_i,
    input wire logic fault_line_oe_o,
    input wire seq_timer_pkg::rail_ctrl_s rail_o,
    input wire logic done_o
);
    logic [CNT_W-1:0] oe_q, gap_q; // Pull-down length; cycles since enables moved
    logic [3:0] en_q; // Enables one cycle back
    logic up, dn; // A rail newly enabled or disabled
    assign up = |(rail_o.enable & ~en_q);
    assign dn = |(en_q & ~rail_o.enable);
    // Pulse length; cleared while undervoltage holds the line as a level
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
        if (!rst_b_i)
            oe_q <= '0;
        else
            oe_q <= (fault_line_oe_o && !input_undervoltage_sense_i) ? oe_q + 1'b1 : '0;
    // Spacing of enable steps
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
        if (!rst_b_i)
        begin
            en_q <= '0;
            gap_q <= '0;
        end
        else
        begin
            en_q <= rail_o.enable;
            gap_q <= (up || dn) ? '0 : gap_q + 1'b1;
        end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    property p_uv; input_undervoltage_sense_i |-> fault_line_oe_o ##1 (rail_o.enable == '0 && !done_o); endproperty
    a_uv: assert property (p_uv) else $error("line free in undervoltage");
    property p_ext; !fault_line_i && !fault_line_oe_o |-> ##[1:2] rail_o.enable == '0; endproperty
    a_ext: assert property (p_ext) else $error("rails on after outside fault");
    property p_pulse; $fell(fault_line_oe_o) && !$past(input_undervoltage_sense_i) |-> oe_q == FAULT_PULSE; endproperty
    a_pulse: assert property (p_pulse) else $error("fault pulse length");
    property p_on; up |-> rail_o.enable == {en_q[2:0], 1'b1}; endproperty
    a_on: assert property (p_on) else $error("enable order");
    property p_gap; (up || dn) && fault_line_i && !fault_line_oe_o |-> gap_q >= DLY_MIN_CYC - 2; endproperty
    a_gap: assert property (p_gap) else $error("step under delay floor");
    property p_off; dn && fault_line_i && !fault_line_oe_o |-> rail_o.enable == en_q >> 1; endproperty
    a_off: assert property (p_off) else $error("disable order");
    property p_bias; $fell(rail_o.enable[3]) && fault_line_i && !fault_line_oe_o |-> ##[0:1] rail_o.bias[3]; endproperty
    a_bias: assert property (p_bias) else $error("no bias on falling rail");
    property p_quiet; |rail_o.bias |-> !fault_line_oe_o; endproperty
    a_quiet: assert property (p_quiet) else $error("fault during power-off");
    c_done: cover property ($rose(done_o));
    c_trip: cover property ($rose(fault_line_oe_o) && !input_undervoltage_sense_i);
    c_bias: cover property ($rose(rail_o.bias[0]));
endmodule
bind seq_timers seq_timers_properties #(.DISCHARGE(DISCHARGE), .FAULT_PULSE(FAULT_PULSE)) i_props (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .input_undervoltage_sense_i(input_undervoltage_sense_i),
    .fault_line_i(fault_line_i),
    .fault_line_oe_o(fault_line_oe_o),
    .rail_o(rail_o),
    .done_o(done_o)
);
`default_nettype wire

/* File: bench/sequencer_delay_and_power_good_timers_test.sv */
// Bench for the sequencer timers: random and corner runs.
// Assumes the rail model and a peer pulling the fault line.
`timescale 1ns/1ps
`default_nettype none
module sequencer_delay_and_power_good_timers_test;
    import seq_timer_pkg::*;
    localparam logic [CNT_W-1:0] DIS = 24'h4; // Short discharge
    localparam logic [CNT_W-1:0] PULSE = 24'h8; // Short fault pulse
    logic clk = 1'b0, rst_b = 1'b0, up = 1'b0, down = 1'b1, uv = 1'b0, peer = 1'b0;
    logic [3:0] stuck = 4'h0, fb; // Rails held down; feedback
    logic [7:0] lag = 8'h10; // Rail ramp cycles
    logic [CNT_W-1:0] dly = 24'h640, power_good_timer_input = 24'hc8;
    logic line, oe, done, fo;
    rail_ctrl_s rail;
    logic [31:0] seed = 32'h0000b0c4;
    int n_fail = 0, checks_done = 0;
    // Wired line: pulled up, low while either side drives it
    assign line = (oe ? fo : 1'b1) && !peer;
    always #12.5 clk = ~clk;
    seq_timers #(.DISCHARGE(DIS), .FAULT_PULSE(PULSE)) i_dut (.sys_clk_i(clk), .rst_b_i(rst_b),
        .power_up_i(up), .power_down_i(down), .feedback_good_i(fb), .input_undervoltage_sense_i(uv),
        .inter_channel_delay_i(dly), .power_good_timeout_i(power_good_timer_input), .fault_line_i(line), .fault_line_o(fo),
        .fault_line_oe_o(oe), .rail_o(rail), .done_o(done));
    rail_model i_rails (.clk_i(clk), .rail_i(rail), .lag_i(lag), .stuck_i(stuck), .good_o(fb));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Count after the floor is applied
    function automatic int eff(input logic [CNT_W-1:0] v, input logic [CNT_W-1:0] fl);
        return v < fl ? int'(fl) : int'(v);
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic summarize();
        if (n_fail == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Cycles until the enables, or the pull-down when sel is set, match pat
    task automatic wait_for(input logic sel, input logic [3:0] pat, output int n);
        n = 0;
        while ((sel ? {3'h0, oe} : rail.enable) !== pat)
        begin
            @(posedge clk);
            n++;
            if (n > 9000)
            begin
                n_fail++;
                summarize();
            end
        end
    endtask
    task automatic power_on(input int last);
        int n;
        int e;
        @(posedge clk);
        up <= 1'b1;
        for (int c = 0; c <= last; c++)
        begin
            wait_for(1'b0, 4'hf >> (3 - c), n);
            // Rail ramp and timer discharge overlap; the longer one paces the step
            e = eff(dly, DLY_MIN_CYC) + (c > 0 ? (int'(lag) > int'(DIS) ? int'(lag) : int'(DIS)) : 0);
            chk("on_gap", 1, n >= e && n <= e + 6);
        end
    endtask
    initial
    begin
        int n;
        int e;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk);
        for (int r = 0; r < 4; r++)
        begin
            // Round 0 sits below both floors; later rounds are random
            dly <= r == 0 ? 24'h5 : 24'h640 + 24'(rnd() % 400);
            power_good_timer_input <= r == 0 ? 24'h3 : 24'hc8 + 24'(rnd() % 100);
            lag <= r == 0 ? 8'h96 : 8'h1 + 8'(rnd() % 60);
            stuck <= r == 2 ? 4'h4 : 4'h0;
            power_on(r == 2 ? 2 : 3);
            if (r == 2)
            begin
                wait_for(1'b1, 4'h1, n);
                e = eff(power_good_timer_input, PGT_MIN_CYC);
                chk("pgt_gap", 1, n + 2 >= e && n <= e + 4);
                repeat (2) @(posedge clk);
                chk("trip_off", 4'h0, rail.enable);
            end
            else if (r == 3)
            begin
                peer <= 1'b1;
                repeat (2) @(posedge clk);
                chk("ext_off", 4'h0, rail.enable);
                peer <= 1'b0;
            end
            else
            begin
                repeat (int'(lag) + 4) @(posedge clk);
                chk("done", 1'b1, done);
                down <= 1'b0;
                // Tied triggers: up falls with down and must not fault
                if (r == 1)
                    up <= 1'b0;
                for (int c = 3; c >= 0; c--)
                begin
                    wait_for(1'b0, 4'hf >> (4 - c), n);
                    e = eff(dly, DLY_MIN_CYC) + (c < 3 ? int'(lag) : 0);
                    chk("off_gap", 1, n >= e && n <= e + int'(DIS) + 8);
                    @(posedge clk);
                    chk("bias", 1'b1, rail.bias[c]);
                end
                // Done drops only once the last rail, rail 0, has bled down
                repeat (int'(lag) + 2) @(posedge clk);
                chk("done_off", 1'b0, done);
                down <= 1'b1;
            end
            up <= 1'b0;
            repeat (400) @(posedge clk);
        end
        uv <= 1'b1;
        repeat (2) @(posedge clk);
        chk("uv_pull", 1'b1, oe);
        chk("line_low", 1'b0, line);
        uv <= 1'b0;
        repeat (20) @(posedge clk);
        summarize();
    end
endmodule
`default_nettype wire

/* File: design/seq_timer_pkg.sv */
// Shared constants and carriers for the sequencer delay and power-good timers.
// Assumes a single 40 MHz system clock and synchronous pin inputs.
package seq_timer_pkg;
    localparam int CHANNELS = 4; // Sequenced rails
    localparam int CLK_MHZ = 40; // System clock rate in MHz
    localparam int DLY_MIN_US = 40; // Minimum inter-channel delay, us
    localparam int DISCHARGE_US = 40; // Delay timer discharge interval, us
    localparam int PGT_MIN_US = 5; // Minimum power-good timeout, us
    localparam int FAULT_PULSE_US = 80; // One-shot fault pulse width, us
    localparam int CNT_W = 24; // Timer counter width
    localparam logic [CNT_W-1:0] DLY_MIN_CYC = CNT_W'(DLY_MIN_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] DISCHARGE_CYC = CNT_W'(DISCHARGE_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] PGT_MIN_CYC = CNT_W'(PGT_MIN_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] FAULT_PULSE_CYC = CNT_W'(FAULT_PULSE_US * CLK_MHZ);

    // Sequencer states
    typedef enum logic [2:0] {
        ST_INIT,
        ST_IDLE_OFF,
        ST_ON_DELAY,
        ST_ON_PGOOD,
        ST_ALL_ON,
        ST_OFF_DELAY,
        ST_OFF_WAIT,
        ST_FAULT
    } seq_state_e;

    // Rail-facing outputs grouped together
    typedef struct packed {
        logic [CHANNELS-1:0] enable; // Rail enables
        logic [CHANNELS-1:0] bias; // Hysteresis bias per feedback input
    } rail_ctrl_s;
endpackage

/* File: design/seq_timers.sv */
// Delay and power-good timer core of a four-channel supply sequencer.
// Assumes feedback comparators and triggers are synchronous to sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
module seq_timers
    import seq_timer_pkg::*;
#(
    parameter logic [seq_timer_pkg::CNT_W-1:0] DISCHARGE = seq_timer_pkg::DISCHARGE_CYC,
    parameter logic [seq_timer_pkg::CNT_W-1:0] FAULT_PULSE = seq_timer_pkg::FAULT_PULSE_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic power_up_i,
    input wire logic power_down_i,
    input wire logic [seq_timer_pkg::CHANNELS-1:0] feedback_good_i,
    input wire logic input_undervoltage_sense_i,
    input wire logic [seq_timer_pkg::CNT_W-1:0] inter_channel_delay_i,
    input wire logic [seq_timer_pkg::CNT_W-1:0] power_good_timeout_i,
    input wire logic fault_line_i,
    output logic fault_line_o,
    output logic fault_line_oe_o,
    output seq_timer_pkg::rail_ctrl_s rail_o,
    output logic done_o
);
    import seq_timer_pkg::*;

    logic rst_meta_q; // Reset synchroniser first stage
    logic rst_b_q; // Released reset copy
    seq_state_e state_q; // Sequencer state
    logic [1:0] chan_q; // Channel being handled
    logic [CNT_W-1:0] tmr_q; // Shared delay / power-good counter
    logic [CNT_W-1:0] dis_q; // Delay timer discharge counter
    logic [CNT_W-1:0] pulse_q; // Fault one-shot counter
    logic up_q; // Previous up trigger
    logic down_q; // Previous down trigger
    logic up_rise; // Up trigger rising edge
    logic down_fall; // Down trigger falling edge
    logic ext_fault; // Peer pulls the line low
    logic [CNT_W-1:0] dly_lim; // Effective delay count
    logic [CNT_W-1:0] pgt_lim; // Effective timeout count
    logic fault_evt; // Internal fault this cycle (timeout or trigger)
    rail_ctrl_s rail_q; // Registered rail outputs

    // Clamp a programmed count to its floor
    function automatic logic [CNT_W-1:0] at_least(input logic [CNT_W-1:0] v, input logic [CNT_W-1:0] lo);
        at_least = (v < lo) ? lo : v;
    endfunction

    // Reset release through two flops
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rst_meta_q <= 1'b0;
            rst_b_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_b_q <= rst_meta_q;
        end
    end

    // Trigger history for edge detection
    always_ff @(posedge sys_clk_i or negedge rst_b_q)
    begin
        if (!rst_b_q)
        begin
            up_q <= 1'b0;
            down_q <= 1'b0;
        end
        else
        begin
            up_q <= power_up_i;
            down_q <= power_down_i;
        end
    end

    assign up_rise = power_up_i && !up_q;
    assign down_fall = !power_down_i && down_q;
    // Own drive excluded so our pulse does not latch us forever
    assign ext_fault = !fault_line_i && !fault_line_oe_o;
    assign dly_lim = at_least(inter_channel_delay_i, DLY_MIN_CYC);
    assign pgt_lim = at_least(power_good_timeout_i, PGT_MIN_CYC);

    // Internal faults that fire the one-shot
    always_comb
    begin
        fault_evt = 1'b0;
        case (state_q)
            ST_ON_PGOOD:
            begin
                // Timeout without feedback good
                fault_evt = !feedback_good_i[chan_q] && (tmr_q + 1'b1 >= pgt_lim);
            end
            ST_ON_DELAY, ST_ALL_ON:
            begin
                // Up may drop once all rails are on, so tied triggers can power down
                fault_evt = up_rise || (!power_up_i && state_q == ST_ON_DELAY);
            end
            default:
            begin
                fault_evt = 1'b0;
            end
        endcase
    end

    // Fault one-shot and undervoltage hold on the shared line
    always_ff @(posedge sys_clk_i or negedge rst_b_q)
    begin
        if (!rst_b_q)
        begin
            pulse_q <= '0;
        end
        else if (fault_evt)
        begin
            pulse_q <= FAULT_PULSE;
        end
        else if (pulse_q != '0)
        begin
            pulse_q <= pulse_q - 1'b1;
        end
    end

    // Open-drain: only ever drive low
    assign fault_line_o = 1'b0;
    assign fault_line_oe_o = (pulse_q != '0) || input_undervoltage_sense_i;

    // Discharge interval after each delay; timer unusable meanwhile
    always_ff @(posedge sys_clk_i or negedge rst_b_q)
    begin
        if (!rst_b_q)
        begin
            dis_q <= '0;
        end
        else if ((state_q == ST_ON_DELAY || state_q == ST_OFF_DELAY) && tmr_q + 1'b1 >= dly_lim && dis_q == '0)
        begin
            dis_q <= DISCHARGE;
        end
        else if (dis_q != '0)
        begin
            dis_q <= dis_q - 1'b1;
        end
    end

    // Sequencer and shared timer
    always_ff @(posedge sys_clk_i or negedge rst_b_q)
    begin
        if (!rst_b_q)
        begin
            state_q <= ST_INIT;
            chan_q <= '0;
            tmr_q <= '0;
            rail_q <= '0;
            done_o <= 1'b0;
        end
        else if (ext_fault || fault_evt || input_undervoltage_sense_i)
        begin
            // All rails off together
            state_q <= ST_FAULT;
            rail_q <= '0;
            tmr_q <= '0;
            done_o <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_INIT, ST_FAULT:
                begin
                    // Leave only once the line is released
                    if (pulse_q == '0 && fault_line_i)
                    begin
                        state_q <= ST_IDLE_OFF;
                    end
                end
                ST_IDLE_OFF:
                begin
                    if (up_rise)
                    begin
                        state_q <= ST_ON_DELAY;
                        chan_q <= '0;
                        tmr_q <= '0;
                    end
                end
                ST_ON_DELAY:
                begin
                    // Counting only once the discharge is over
                    if (dis_q != '0)
                    begin
                        tmr_q <= '0;
                    end
                    else if (tmr_q + 1'b1 >= dly_lim)
                    begin
                        rail_q.enable[chan_q] <= 1'b1;
                        state_q <= ST_ON_PGOOD;
                        tmr_q <= '0;
                    end
                    else
                    begin
                        tmr_q <= tmr_q + 1'b1;
                    end
                end
                ST_ON_PGOOD:
                begin
                    if (feedback_good_i[chan_q])
                    begin
                        tmr_q <= '0;
                        if (chan_q == 2'(CHANNELS - 1))
                        begin
                            state_q <= ST_ALL_ON;
                            done_o <= 1'b1;
                        end
                        else
                        begin
                            chan_q <= chan_q + 1'b1;
                            state_q <= ST_ON_DELAY;
                        end
                    end
                    else
                    begin
                        tmr_q <= tmr_q + 1'b1;
                    end
                end
                ST_ALL_ON:
                begin
                    if (down_fall)
                    begin
                        state_q <= ST_OFF_DELAY;
                        tmr_q <= '0;
                    end
                end
                ST_OFF_DELAY:
                begin
                    if (dis_q != '0)
                    begin
                        tmr_q <= '0;
                    end
                    else if (tmr_q + 1'b1 >= dly_lim)
                    begin
                        rail_q.enable[chan_q] <= 1'b0;
                        rail_q.bias[chan_q] <= 1'b1;
                        state_q <= ST_OFF_WAIT;
                        tmr_q <= '0;
                    end
                    else
                    begin
                        tmr_q <= tmr_q + 1'b1;
                    end
                end
                ST_OFF_WAIT:
                begin
                    // No timeout here, feedback just has to fall
                    if (!feedback_good_i[chan_q])
                    begin
                        rail_q.bias[chan_q] <= 1'b0;
                        if (chan_q == '0)
                        begin
                            state_q <= ST_IDLE_OFF;
                            done_o <= 1'b0;
                        end
                        else
                        begin
                            chan_q <= chan_q - 1'b1;
                            state_q <= ST_OFF_DELAY;
                        end
                    end
                end
                default:
                begin
                    state_q <= ST_INIT;
                end
            endcase
        end
    end

    assign rail_o = rail_q;
endmodule
`default_nettype wire
